// ### logic/ced_cfg.svh
// Constants for the clock enable and divider block.
`ifndef CED_CFG_SVH
`define CED_CFG_SVH

`define CED_DIV_W        4
`define CED_STG_W        8
`define CED_WORD_W       12
`define CED_MULT_W       8
`define CED_WORD_RST     12'h000
`define CED_WORD_MAX     12'h9ff
`define CED_DIV_SLOWEST  4'h9
`define CED_STEP_FINE    12'h001
`define CED_STEP_MID     12'h008
`define CED_STEP_COARSE  12'h020
`define CED_N_BYPASS     8'h01
`define CED_F_NOM_HZ     307200
`define CED_F_TOL_PCT    25
`define CED_STABLE_PCT   5

`endif

// ### logic/ced_pkg.sv
// Types for the clock enable and divider block.
`default_nettype none
package ced_pkg;
  // Frequency error band of the base clock, as reported by the comparator.
  typedef enum logic [2:0] {
    CED_BAND_LT085,
    CED_BAND_085_095,
    CED_BAND_095_100,
    CED_BAND_100_105,
    CED_BAND_105_115,
    CED_BAND_GT115
  } ced_band_e;
endpackage
`default_nettype wire

// ### logic/ced_top.sv
// Clock enable gating, digital oscillator model, loop filter and modulo-N divider.
//
// Function
// - Stop mode asserts generator stop and disables the whole generator.
// - Generator stop holds fast and external clocks low, and base too unless it comes while base is high and fast is low.
// - Internal enable equals generator-on bit and not generator stop.
// - Internal enable low turns generator off, fast clock low; base goes low unless enable drops while base is high and fast is low.
// - External enable equals external-on bit and not generator stop.
// - External enable low holds external clock output low.
// - Bus clock is oscillator clock over four, generator clock over two.
// - Fast clock is the multiplier factor times the base clock.
// - Base clock is the fast clock divided by the multiplier factor.
// - Factor zero or one bypasses the divider, passing fast clock through.
// - Oscillator period set by 8-bit stage and 4-bit divider fields.
// - Concatenated control word is valid only from zero to 9FF.
// - Settled base clock sits at nominal 307.2 kHz within 25 percent.
// - Loop filter adds or subtracts 1, 8 or 32 by error band.
// - Divider values A through F act like 9, the slowest setting.
// - Filter stable flag set when error is within 5 percent.
// - Divider field moves only on stage field carry or borrow.
`include "ced_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ced_top
  import ced_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     stop_mode,
  input  wire logic                     internal_generator_on,
  input  wire logic                     external_generator_on,
  input  wire logic [`CED_MULT_W-1:0]   multiplier_register,
  input  wire logic [2:0]               freq_band,
  input  wire logic                     ext_clk_src,
  output logic                          generator_stop,
  output logic                          internal_clock_enable,
  output logic                          external_clock_enable,
  output logic                          fast_internal_clock,
  output logic                          low_freq_base_clock,
  output logic                          external_clock_signal,
  output logic                          oscillator_output_clock,
  output logic                          generator_output_clock,
  output logic                          bus_clock,
  output logic [`CED_STG_W-1:0]         oscillator_stage_control,
  output logic [`CED_DIV_W-1:0]         oscillator_divider_control,
  output logic                          control_word_valid,
  output logic                          filter_stable_flag
);

  // Divider codes above the slowest one run the oscillator at the slowest rate.
  function automatic logic [`CED_DIV_W-1:0] eff_div(input logic [`CED_DIV_W-1:0] d);
    eff_div = (d > `CED_DIV_SLOWEST) ? `CED_DIV_SLOWEST : d;
  endfunction

  // Two's complement correction added to the control word for each error band.
  function automatic logic [`CED_WORD_W-1:0] band_step(input ced_band_e b);
    unique case (b)
      CED_BAND_LT085:   band_step = -`CED_STEP_COARSE;
      CED_BAND_085_095: band_step = -`CED_STEP_MID;
      CED_BAND_095_100: band_step = -`CED_STEP_FINE;
      CED_BAND_100_105: band_step = `CED_STEP_FINE;
      CED_BAND_105_115: band_step = `CED_STEP_MID;
      CED_BAND_GT115:   band_step = `CED_STEP_COARSE;
      default:          band_step = '0;
    endcase
  endfunction

  logic                      stop_reg;
  logic [`CED_WORD_W-1:0]    word_reg;
  logic                      stable_reg;
  logic [`CED_DIV_W-1:0]     half_cnt_reg;
  logic [`CED_STG_W-1:0]     dither_reg;
  logic                      fast_reg;
  logic [`CED_MULT_W-1:0]    div_cnt_reg;
  logic                      base_reg;
  logic                      ext_reg;
  logic                      gen_reg;
  logic                      bus_reg;

  logic                      half_end;
  logic                      fast_rise;
  logic                      fast_fall;
  logic                      bypass;
  logic                      base_next;
  logic                      base_rise;
  logic [`CED_STG_W:0]       dither_sum;
  logic [`CED_MULT_W-1:0]    last_cnt;
  ced_band_e                 band;

  assign band = ced_band_e'(freq_band);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_reg <= 1'b0;
    end else if (clk_en) begin
      stop_reg <= stop_mode;
    end
  end

  assign generator_stop = stop_reg;
  assign internal_clock_enable = internal_generator_on & ~stop_reg;
  assign external_clock_enable = external_generator_on & ~stop_reg;

  assign oscillator_stage_control   = word_reg[`CED_STG_W-1:0];
  assign oscillator_divider_control = word_reg[`CED_WORD_W-1:`CED_STG_W];
  assign control_word_valid = (word_reg <= `CED_WORD_MAX);

  // The oscillator model: each half period lasts eff_div+1 system cycles, and
  // the stage field dithers in one extra cycle on each accumulator carry, so a
  // larger word up to 9FF gives a slower clock, as the loop filter expects.
  assign half_end   = (half_cnt_reg == '0);
  assign fast_rise  = half_end & ~fast_reg & internal_clock_enable;
  assign fast_fall  = half_end & fast_reg;
  assign dither_sum = {1'b0, dither_reg} + {1'b0, oscillator_stage_control};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_reg <= '0;
      dither_reg   <= '0;
      fast_reg     <= 1'b0;
    end else if (clk_en) begin
      if (fast_rise || fast_fall) begin
        half_cnt_reg <= eff_div(oscillator_divider_control) + {3'h0, dither_sum[`CED_STG_W]};
        dither_reg   <= dither_sum[`CED_STG_W-1:0];
        // A started high phase always completes before the clock stops.
        fast_reg     <= ~fast_reg;
      end else if (!half_end) begin
        half_cnt_reg <= half_cnt_reg - 4'h1;
      end
    end
  end

  assign bypass   = (multiplier_register <= `CED_N_BYPASS);
  assign last_cnt = multiplier_register - 8'h01;

  always_comb begin
    base_next = base_reg;
    if (bypass) begin
      base_next = fast_reg ^ (fast_rise | fast_fall);
    end else if (fast_rise) begin
      // One base pulse per N fast cycles.
      base_next = (div_cnt_reg == last_cnt);
    end else if (fast_fall && !internal_clock_enable) begin
      // Base drops with the last fast pulse.
      base_next = 1'b0;
    end
  end

  assign base_rise = base_next & ~base_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= '0;
      base_reg    <= 1'b0;
    end else if (clk_en) begin
      base_reg <= base_next;
      if (bypass || (!internal_clock_enable && !fast_reg)) begin
        div_cnt_reg <= '0;
      end else if (fast_rise) begin
        // Fast cycles counted per base period.
        div_cnt_reg <= (div_cnt_reg >= last_cnt) ? '0 : div_cnt_reg + 8'h01;
      end
    end
  end

  // The loop filter acts once per base period, on the comparator's band.
  // Band correction.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_reg   <= `CED_WORD_RST;
      stable_reg <= 1'b0;
    end else if (clk_en) begin
      if (base_rise) begin
        // Plain 12-bit add carries stage into divider.
        word_reg   <= word_reg + band_step(band);
        stable_reg <= (band == CED_BAND_095_100) || (band == CED_BAND_100_105);
      end
    end
  end

  // External path: rises only with the source while enabled, and once high it
  // follows the source down, so stopping never clips a pulse.
  // External gating.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_reg <= 1'b0;
    end else if (clk_en) begin
      if (!ext_clk_src) begin
        ext_reg <= 1'b0;
      end else if (external_clock_enable && !ext_reg) begin
        ext_reg <= 1'b1;
      end
    end
  end

  // Divide-by-two chain for generator and bus clocks.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gen_reg <= 1'b0;
      bus_reg <= 1'b0;
    end else if (clk_en) begin
      if (fast_rise) begin
        gen_reg <= ~gen_reg;
        if (!gen_reg) begin
          bus_reg <= ~bus_reg;
        end
      end
    end
  end

  // Fast and external outputs held low while stopped, base too unless stopped with base high and fast low; generator and bus clocks keep their last level.
  assign fast_internal_clock     = fast_reg;
  assign low_freq_base_clock     = base_reg;
  assign external_clock_signal   = ext_reg;
  assign oscillator_output_clock = fast_reg;
  assign generator_output_clock  = gen_reg;
  assign bus_clock               = bus_reg;
  // Nominal rate is the comparator's target.
  assign filter_stable_flag      = stable_reg;

endmodule // ced_top

`default_nettype wire

// ### verif/ced_sim_model.sv
// Clock consumer model that counts rising edges of the four generator clocks.
`timescale 1ns/10ps
`default_nettype none
module ced_sim_model (
  input  wire logic        clk_sys,
  input  wire logic        clr,
  input  wire logic [3:0]  clks,
  output logic      [15:0] cnt [4]
);
  logic [3:0] prev_reg;
  always_ff @(posedge clk_sys) begin
    prev_reg <= clks;
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        cnt[i] <= 16'h0000;
      end else if (clks[i] && !prev_reg[i]) begin
        cnt[i] <= cnt[i] + 16'h0001;
      end
    end
  end
endmodule // ced_sim_model
`default_nettype wire

// ### verif/ced_top_properties.sv
// Concurrent checks on the clock enable and divider ports.
`include "ced_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ced_top_properties (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic                   clk_en,
  input wire logic                   stop_mode,
  input wire logic                   internal_generator_on,
  input wire logic                   external_generator_on,
  input wire logic [`CED_MULT_W-1:0] multiplier_register,
  input wire logic                   generator_stop,
  input wire logic                   internal_clock_enable,
  input wire logic                   external_clock_enable,
  input wire logic                   fast_internal_clock,
  input wire logic                   low_freq_base_clock,
  input wire logic                   external_clock_signal,
  input wire logic                   oscillator_output_clock,
  input wire logic [`CED_STG_W-1:0]  oscillator_stage_control,
  input wire logic [`CED_DIV_W-1:0]  oscillator_divider_control,
  input wire logic                   control_word_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_stop_follows_mode: assert property (clk_en |=> generator_stop == $past(stop_mode))
    else $error("generator stop does not follow stop mode");
  a_int_enable_eq: assert property (internal_clock_enable == (internal_generator_on && !generator_stop))
    else $error("internal enable wrong");
  a_ext_enable_eq: assert property (external_clock_enable == (external_generator_on && !generator_stop))
    else $error("external enable wrong");
  a_fast_held_low: assert property (!internal_clock_enable && !fast_internal_clock |=> !fast_internal_clock)
    else $error("fast clock started while disabled");
  a_base_held_low: assert property (!internal_clock_enable && !fast_internal_clock
    && !low_freq_base_clock |=> !low_freq_base_clock)
    else $error("base clock rose while disabled");
  a_ext_held_low: assert property (!external_clock_enable && !external_clock_signal
    |=> !external_clock_signal)
    else $error("external clock rose while disabled");
  a_osc_is_fast: assert property (oscillator_output_clock == fast_internal_clock)
    else $error("oscillator clock differs from fast clock");
  a_word_range_flag: assert property (control_word_valid ==
    ({oscillator_divider_control, oscillator_stage_control} <= `CED_WORD_MAX))
    else $error("valid flag disagrees with word");
  a_bypass_passes: assert property (multiplier_register <= 8'h01 && $past(multiplier_register) <= 8'h01
    && $past(multiplier_register, 2) <= 8'h01 |-> low_freq_base_clock == fast_internal_clock)
    else $error("bypass does not pass fast clock");
  a_word_on_base: assert property ($changed({oscillator_divider_control, oscillator_stage_control})
    |-> $rose(low_freq_base_clock))
    else $error("control word moved off a base rise");
  cover property ($rose(generator_stop));
  cover property (!control_word_valid);
  cover property ($rose(low_freq_base_clock) && multiplier_register == 8'h02);
endmodule // ced_top_properties
bind ced_top ced_top_properties i_props (.clk_sys, .rst_n, .clk_en, .stop_mode, .internal_generator_on,
  .external_generator_on, .multiplier_register, .generator_stop, .internal_clock_enable, .external_clock_enable,
  .fast_internal_clock, .low_freq_base_clock, .external_clock_signal, .oscillator_output_clock,
  .oscillator_stage_control, .oscillator_divider_control, .control_word_valid);
`default_nettype wire

// ### verif/ced_top_tb.sv
// Self-checking bench for the clock enable and divider block.
`timescale 1ns/10ps
`default_nettype none
module ced_top_tb;
  logic clk_sys = 0, rst_n = 0, clk_en = 1, stop_mode = 0, ion = 1, eon = 1, src = 0, clr = 0;
  logic [7:0] mult = 8'h00;
  logic [2:0] band = 3'h6;
  logic [15:0] cnt [4];
  logic fast, base, gen, bus, ext, ice, ece, gstop, valid, stable;
  logic [7:0] stg;
  logic [3:0] div;
  int failures = 0, cmp_count = 0, cyc = 0;
  logic [11:0] words [8] = '{12'h020, 12'h028, 12'h029, 12'h028, 12'h020, 12'h000, 12'hfe0, 12'h000};
  logic [2:0] bands [8] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h5};
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) src <= ~src;
  ced_top i_dut (.clk_sys, .rst_n, .clk_en, .stop_mode, .internal_generator_on(ion), .external_generator_on(eon),
    .multiplier_register(mult), .freq_band(band), .ext_clk_src(src), .generator_stop(gstop),
    .internal_clock_enable(ice), .external_clock_enable(ece), .fast_internal_clock(fast),
    .low_freq_base_clock(base), .external_clock_signal(ext), .oscillator_output_clock(), .generator_output_clock(gen),
    .bus_clock(bus), .oscillator_stage_control(stg), .oscillator_divider_control(div),
    .control_word_valid(valid), .filter_stable_flag(stable));
  ced_sim_model i_sim (.clk_sys, .clr, .clks({base, bus, gen, fast}), .cnt);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic near(input logic [15:0] a, input logic [15:0] b, input logic [15:0] tol);
    chk(((a > b) ? a - b : b - a) <= tol, 16'h0001);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic measure();
    step(1);
    clr <= 1;
    step(1);
    clr <= 0;
    step(600);
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    step(3);
    rst_n <= 1;
    for (int i = 0; i < 4; i++) begin
      step(1);
      mult <= 8'(i * 2 - 1 + (i == 0));
      measure();
      near(cnt[3] * ((mult < 2) ? 16'h0001 : 16'(mult)), cnt[0], 16'h0008);
    end
    near(cnt[1] * 16'h0002, cnt[0], 16'h0004);
    near(cnt[2] * 16'h0004, cnt[0], 16'h0008);
    $display("divider test done");
    step(1);
    mult <= 8'h02;
    @(posedge base);
    step(1);
    band <= bands[0];
    foreach (words[i]) begin
      @(posedge base);
      #1;
      chk({div, stg}, words[i]);
      chk(valid, words[i] <= 12'h9ff);
      chk(stable, bands[i] inside {3'h2, 3'h3});
      step(1);
      band <= (i < 7) ? bands[i + 1] : 3'h6;
    end
    // A band code outside the six corrections must leave the word alone.
    @(posedge base);
    #1;
    chk({div, stg}, 12'h000);
    $display("filter test done");
    chk(ext, !src);
    step(1);
    stop_mode <= 1;
    step(30);
    #1;
    chk({gstop, ice, ece}, 3'h4);
    chk({fast, base, ext}, 3'h0);
    step(1);
    stop_mode <= 0;
    ion <= 0;
    step(30);
    #1;
    chk({ice, fast, base}, 3'h0);
    chk(ext, !src);
    step(1);
    eon <= 0;
    ion <= 1;
    step(30);
    #1;
    chk(ext, 1'b0);
    measure();
    chk(cnt[0] != 16'h0000, 16'h0001);
    // With the clock enable low nothing may move, not even the stop capture.
    step(1);
    clk_en <= 0;
    stop_mode <= 1;
    measure();
    chk(gstop, 1'b0);
    chk(cnt[0], 16'h0000);
    $display("enable test done");
    end_sim();
  end
endmodule // ced_top_tb
`default_nettype wire
